// ### src/dma_flag_pkg.sv
// Purpose: shared constants and types for the DMA channel flag block
// Assumes: 32-bit Avalon-MM register port, word addressed by byte offset
// Notes: each channel owns one four-bit group of flags
package dma_flag_pkg;

    localparam int NUM_CHAN = 8;
    localparam int GRP_W = 4;
    localparam int DATA_W = 32;
    localparam int ADDR_W = 4;

    // Flag positions inside one channel group
    localparam int FLD_ANY = 0;
    localparam int FLD_DONE = 1;
    localparam int FLD_HALF = 2;
    localparam int FLD_ERR = 3;

    // Register byte offsets
    localparam logic [ADDR_W-1:0] OFS_STATUS = 4'h0;
    localparam logic [ADDR_W-1:0] OFS_CLEAR = 4'h4;

    localparam logic [DATA_W-1:0] FLAG_RESET = 32'h0000_0000;
    localparam logic [DATA_W-1:0] READ_ZERO = 32'h0000_0000;

    typedef struct packed {
        logic err;
        logic half;
        logic done;
    } chan_events_t;

    typedef struct packed {
        logic read;
        logic write;
        logic [ADDR_W-1:0] address;
        logic [DATA_W-1:0] writedata;
    } bus_req_t;

endpackage : dma_flag_pkg

// ### src/dma_chan_flags.sv
// Purpose: four sticky event flags of one DMA channel
// Assumes: events and clears are one-cycle synchronous pulses
// Notes: a set in the same cycle as a clear wins
`timescale 1ns/1ps
`default_nettype none
module dma_chan_flags
    import dma_flag_pkg::*;
(
    input wire logic i_clk,
    input wire logic i_reset_n,
    input wire dma_flag_pkg::chan_events_t i_events,
    input wire logic [dma_flag_pkg::GRP_W-1:0] i_clear,
    output logic [dma_flag_pkg::GRP_W-1:0] o_flags
);
    logic [GRP_W-1:0] set_vec;
    logic [GRP_W-1:0] clr_vec;

    always_comb
    begin
        set_vec = '0;
        set_vec[FLD_ANY] = i_events.err | i_events.half | i_events.done;
        set_vec[FLD_DONE] = i_events.done;
        set_vec[FLD_HALF] = i_events.half;
        set_vec[FLD_ERR] = i_events.err;
        // Group clear bit wipes all four flags
        clr_vec = i_clear[FLD_ANY] ? {GRP_W{1'b1}} : i_clear;
    end

    always_ff @(posedge i_clk or negedge i_reset_n)
    begin
        if (!i_reset_n)
            o_flags <= FLAG_RESET[GRP_W-1:0];
        else
            o_flags <= set_vec | (o_flags & ~clr_vec);
    end

    property p_set_wins;
        @(posedge i_clk) disable iff (!i_reset_n)
        i_events.done |=> o_flags[FLD_DONE] && o_flags[FLD_ANY];
    endproperty
    a_set_wins: assert property (p_set_wins) else $error("done event lost");

    property p_group_clear;
        @(posedge i_clk) disable iff (!i_reset_n)
        (i_clear[FLD_ANY] && !i_events.err && !i_events.half && !i_events.done) |=> o_flags == '0;
    endproperty
    a_group_clear: assert property (p_group_clear) else $error("group clear failed");

    property p_err_clear;
        @(posedge i_clk) disable iff (!i_reset_n)
        (i_clear[FLD_ERR] && !i_events.err) |=> !o_flags[FLD_ERR];
    endproperty
    a_err_clear: assert property (p_err_clear) else $error("error flag not cleared");

    property p_half_set;
        @(posedge i_clk) disable iff (!i_reset_n)
        i_events.half |=> o_flags[FLD_HALF];
    endproperty
    a_half_set: assert property (p_half_set) else $error("half flag not set");

    property p_err_set;
        @(posedge i_clk) disable iff (!i_reset_n)
        i_events.err |=> o_flags[FLD_ERR] && o_flags[FLD_ANY];
    endproperty
    a_err_set: assert property (p_err_set) else $error("error flag not set");

    property p_no_spurious;
        @(posedge i_clk) disable iff (!i_reset_n)
        (!o_flags[FLD_DONE] && !i_events.done) |=> !o_flags[FLD_DONE];
    endproperty
    a_no_spurious: assert property (p_no_spurious) else $error("done flag rose without event");

    property p_zero_noop;
        @(posedge i_clk) disable iff (!i_reset_n)
        (i_clear == '0) |=> (o_flags & $past(o_flags)) == $past(o_flags);
    endproperty
    a_zero_noop: assert property (p_zero_noop) else $error("flag dropped without clear");

endmodule : dma_chan_flags
`default_nettype wire

// ### src/dma_channel_flag_status.sv
// Purpose: DMA flag status and flag clear registers on Avalon-MM
// Assumes: one clock, event pulses synchronous to it
// Notes: status is read-only; clear is write-one-to-clear, reads zero
//
// Notes on behaviour
// - Channel 4 error flag sits at status bit 19.
// - Channel 5 flags in bits 20-23: any, done, halfway, error.
// - Channel 6 flags in bits 24-27, same order.
// - Channel 7 flags in bits 28-31, same order.
// - Any-event flag sets on error, halfway or done event.
// - Done flag sets when the channel finishes its transfer.
// - Halfway flag sets when half the transfer has moved.
// - Error flag sets on a transfer error.
// - Flags set only by hardware; status register ignores writes.
// - Software writes one to clear register bit; flag then drops.
// - Flags reset to zero and stay zero without events.
// - Group clear bit clears all four flags; zero bits do nothing.
// - Clear register at offset 0x04, layout mirrors status.
// - Channel n occupies bits 4n to 4n+3.
`timescale 1ns/1ps
`default_nettype none
module dma_channel_flag_status
    import dma_flag_pkg::*;
#(
    parameter int CHANNELS = NUM_CHAN
)
(
    input wire logic i_clk,
    input wire logic i_reset_n,
    input wire dma_flag_pkg::chan_events_t [CHANNELS-1:0] i_chan_events,
    input wire dma_flag_pkg::bus_req_t i_bus,
    output logic [dma_flag_pkg::DATA_W-1:0] o_readdata,
    output logic o_readdatavalid,
    output logic o_waitrequest,
    output logic [dma_flag_pkg::DATA_W-1:0] o_flag_status
);

    // ---------------------------------------------
    // Bus handshake
    // ---------------------------------------------
    // One wait cycle per access: keeps readdata registered
    logic ack_r;
    logic req;
    logic clear_hit;
    logic [DATA_W-1:0] flags;
    logic [DATA_W-1:0] clear_vec;

    assign req = i_bus.read | i_bus.write;
    // Clear lands on the edge where the master sees waitrequest low
    assign clear_hit = i_bus.write && ack_r && (i_bus.address == OFS_CLEAR);
    // Writes to the status offset fall through with no effect
    assign clear_vec = clear_hit ? i_bus.writedata : READ_ZERO;

    always_ff @(posedge i_clk or negedge i_reset_n)
    begin
        if (!i_reset_n)
            ack_r <= 1'b0;
        else
            ack_r <= req && !ack_r;
    end

    always_ff @(posedge i_clk or negedge i_reset_n)
    begin
        if (!i_reset_n)
            o_waitrequest <= 1'b1;
        else
            o_waitrequest <= !(req && !ack_r);
    end

    always_ff @(posedge i_clk or negedge i_reset_n)
    begin
        if (!i_reset_n)
            o_readdatavalid <= 1'b0;
        else
            o_readdatavalid <= i_bus.read && !ack_r;
    end

    always_ff @(posedge i_clk or negedge i_reset_n)
    begin
        if (!i_reset_n)
            o_readdata <= READ_ZERO;
        else if (i_bus.read && !ack_r)
            o_readdata <= (i_bus.address == OFS_STATUS) ? flags : READ_ZERO;
    end

    // ---------------------------------------------
    // Per-channel flag groups
    // ---------------------------------------------
    // Channel g lands at bits 4g..4g+3: covers channels 4 to 7 too
    for (genvar g = 0; g < CHANNELS; g++)
    begin : g_chan
        dma_chan_flags u_flags (
            .i_clk(i_clk),
            .i_reset_n(i_reset_n),
            .i_events(i_chan_events[g]),
            .i_clear(clear_vec[g*GRP_W +: GRP_W]),
            .o_flags(flags[g*GRP_W +: GRP_W])
        );
    end

    always_ff @(posedge i_clk or negedge i_reset_n)
    begin
        if (!i_reset_n)
            o_flag_status <= FLAG_RESET;
        else
            o_flag_status <= flags;
    end

    // ---------------------------------------------
    // Checks
    // ---------------------------------------------
    property p_ch4_err_bit;
        @(posedge i_clk) disable iff (!i_reset_n)
        i_chan_events[4].err |=> flags[19];
    endproperty
    a_ch4_err_bit: assert property (p_ch4_err_bit) else $error("ch4 error not at bit 19");

    property p_ch5_layout;
        @(posedge i_clk) disable iff (!i_reset_n)
        i_chan_events[5].done |=> flags[21] && flags[20];
    endproperty
    a_ch5_layout: assert property (p_ch5_layout) else $error("ch5 layout wrong");

    property p_ch6_layout;
        @(posedge i_clk) disable iff (!i_reset_n)
        i_chan_events[6].half |=> flags[26] && flags[24];
    endproperty
    a_ch6_layout: assert property (p_ch6_layout) else $error("ch6 layout wrong");

    property p_ch7_layout;
        @(posedge i_clk) disable iff (!i_reset_n)
        i_chan_events[7].err |=> flags[31] && flags[28];
    endproperty
    a_ch7_layout: assert property (p_ch7_layout) else $error("ch7 layout wrong");

    sequence s_access;
        req && !ack_r;
    endsequence
    sequence s_answer;
        ##1 !o_waitrequest ##1 o_waitrequest;
    endsequence
    property p_one_wait;
        @(posedge i_clk) disable iff (!i_reset_n)
        s_access |-> s_answer;
    endproperty
    a_one_wait: assert property (p_one_wait) else $error("access not answered in one cycle");

    sequence s_read_take;
        i_bus.read && !ack_r;
    endsequence
    sequence s_read_answer;
        ##1 (o_readdatavalid && !o_waitrequest);
    endsequence
    property p_read_answer;
        @(posedge i_clk) disable iff (!i_reset_n)
        s_read_take |-> s_read_answer;
    endproperty
    a_read_answer: assert property (p_read_answer) else $error("read answer missing");

    property p_write_answer;
        @(posedge i_clk) disable iff (!i_reset_n)
        (i_bus.write && !ack_r) |=> !o_waitrequest && !o_readdatavalid;
    endproperty
    a_write_answer: assert property (p_write_answer) else $error("write answer wrong");

    property p_idle_wait;
        @(posedge i_clk) disable iff (!i_reset_n)
        !req |=> o_waitrequest && !o_readdatavalid;
    endproperty
    a_idle_wait: assert property (p_idle_wait) else $error("waitrequest dropped while idle");

    property p_ack_pulse;
        @(posedge i_clk) disable iff (!i_reset_n)
        ack_r |=> !ack_r;
    endproperty
    a_ack_pulse: assert property (p_ack_pulse) else $error("acknowledge stuck high");

    property p_status_read;
        @(posedge i_clk) disable iff (!i_reset_n)
        (i_bus.read && !ack_r && i_bus.address == OFS_STATUS) |=> o_readdata == $past(flags);
    endproperty
    a_status_read: assert property (p_status_read) else $error("status read data wrong");

    property p_clear_reads_zero;
        @(posedge i_clk) disable iff (!i_reset_n)
        (i_bus.read && !ack_r && i_bus.address == OFS_CLEAR) |=> o_readdata == READ_ZERO;
    endproperty
    a_clear_reads_zero: assert property (p_clear_reads_zero) else $error("clear register read not zero");

    property p_unmapped_read;
        @(posedge i_clk) disable iff (!i_reset_n)
        (i_bus.read && !ack_r && i_bus.address != OFS_STATUS && i_bus.address != OFS_CLEAR)
            |=> o_readdata == READ_ZERO;
    endproperty
    a_unmapped_read: assert property (p_unmapped_read) else $error("unmapped read not zero");

    property p_readdata_holds;
        @(posedge i_clk) disable iff (!i_reset_n)
        !(i_bus.read && !ack_r) |=> $stable(o_readdata);
    endproperty
    a_readdata_holds: assert property (p_readdata_holds) else $error("read data changed without a read");

    property p_write_at_accept;
        @(posedge i_clk) disable iff (!i_reset_n)
        clear_hit |-> !o_waitrequest;
    endproperty
    a_write_at_accept: assert property (p_write_at_accept) else $error("clear applied before acceptance");

    property p_status_write_noop;
        @(posedge i_clk) disable iff (!i_reset_n)
        (i_bus.write && i_bus.address == OFS_STATUS) |-> clear_vec == READ_ZERO;
    endproperty
    a_status_write_noop: assert property (p_status_write_noop) else $error("status write had effect");

    property p_clear_ch5;
        @(posedge i_clk) disable iff (!i_reset_n)
        (clear_hit && i_bus.writedata[20] && i_chan_events[5] == '0) |=> flags[23:20] == 4'h0;
    endproperty
    a_clear_ch5: assert property (p_clear_ch5) else $error("ch5 group clear failed");

    property p_out_tracks;
        @(posedge i_clk) disable iff (!i_reset_n)
        1'b1 |=> o_flag_status == $past(flags);
    endproperty
    a_out_tracks: assert property (p_out_tracks) else $error("status output lags wrongly");

    // Remaining field positions of channels 4 to 7, plus one low channel
    property p_ch4_any;
        @(posedge i_clk) disable iff (!i_reset_n)
        (i_chan_events[4] != '0) |=> flags[16];
    endproperty
    a_ch4_any: assert property (p_ch4_any) else $error("ch4 any-event flag not at bit 16");

    property p_ch4_done;
        @(posedge i_clk) disable iff (!i_reset_n)
        i_chan_events[4].done |=> flags[17];
    endproperty
    a_ch4_done: assert property (p_ch4_done) else $error("ch4 done flag not at bit 17");

    property p_ch4_half;
        @(posedge i_clk) disable iff (!i_reset_n)
        i_chan_events[4].half |=> flags[18];
    endproperty
    a_ch4_half: assert property (p_ch4_half) else $error("ch4 halfway flag not at bit 18");

    property p_ch5_half;
        @(posedge i_clk) disable iff (!i_reset_n)
        i_chan_events[5].half |=> flags[22];
    endproperty
    a_ch5_half: assert property (p_ch5_half) else $error("ch5 halfway flag not at bit 22");

    property p_ch5_err;
        @(posedge i_clk) disable iff (!i_reset_n)
        i_chan_events[5].err |=> flags[23];
    endproperty
    a_ch5_err: assert property (p_ch5_err) else $error("ch5 error flag not at bit 23");

    property p_ch6_done;
        @(posedge i_clk) disable iff (!i_reset_n)
        i_chan_events[6].done |=> flags[25];
    endproperty
    a_ch6_done: assert property (p_ch6_done) else $error("ch6 done flag not at bit 25");

    property p_ch6_err;
        @(posedge i_clk) disable iff (!i_reset_n)
        i_chan_events[6].err |=> flags[27];
    endproperty
    a_ch6_err: assert property (p_ch6_err) else $error("ch6 error flag not at bit 27");

    property p_ch7_done;
        @(posedge i_clk) disable iff (!i_reset_n)
        i_chan_events[7].done |=> flags[29];
    endproperty
    a_ch7_done: assert property (p_ch7_done) else $error("ch7 done flag not at bit 29");

    property p_ch7_half;
        @(posedge i_clk) disable iff (!i_reset_n)
        i_chan_events[7].half |=> flags[30];
    endproperty
    a_ch7_half: assert property (p_ch7_half) else $error("ch7 halfway flag not at bit 30");

    property p_ch2_any;
        @(posedge i_clk) disable iff (!i_reset_n)
        (i_chan_events[2] != '0) |=> flags[8];
    endproperty
    a_ch2_any: assert property (p_ch2_any) else $error("ch2 any-event flag not at bit 8");

    property p_ch6_set_wins;
        @(posedge i_clk) disable iff (!i_reset_n)
        (clear_hit && i_bus.writedata[24] && i_chan_events[6].err) |=> flags[27] && flags[24];
    endproperty
    a_ch6_set_wins: assert property (p_ch6_set_wins) else $error("ch6 error lost to clear");

    property p_ch7_hw_only;
        @(posedge i_clk) disable iff (!i_reset_n)
        (!flags[29] && !i_chan_events[7].done) |=> !flags[29];
    endproperty
    a_ch7_hw_only: assert property (p_ch7_hw_only) else $error("ch7 done flag set without event");

    property p_quiet;
        @(posedge i_clk) disable iff (!i_reset_n)
        (i_chan_events == '0 && clear_vec == '0) |=> $stable(flags);
    endproperty
    a_quiet: assert property (p_quiet) else $error("flags moved with no event or clear");

    property p_ch4_group_clear;
        @(posedge i_clk) disable iff (!i_reset_n)
        (clear_hit && i_bus.writedata[16] && i_chan_events[4] == '0) |=> flags[19:16] == 4'h0;
    endproperty
    a_ch4_group_clear: assert property (p_ch4_group_clear) else $error("ch4 group clear failed");

    property p_zero_clear;
        @(posedge i_clk) disable iff (!i_reset_n)
        (clear_hit && i_bus.writedata == '0) |=> (flags & $past(flags)) == $past(flags);
    endproperty
    a_zero_clear: assert property (p_zero_clear) else $error("zero clear write dropped a flag");

endmodule : dma_channel_flag_status
`default_nettype wire

// ### tb/test_dma_channel_flag_status.sv
// Purpose: self-checking bench for the DMA flag status block
// Assumes: one wait state per access, events one-cycle pulses
// Notes: flag word judged on o_flag_status and by bus reads
`timescale 1ns/1ps
`default_nettype none
module test_dma_channel_flag_status;
    import dma_flag_pkg::*;
    logic i_clk;
    logic i_reset_n;
    chan_events_t [NUM_CHAN-1:0] ev;
    bus_req_t bus;
    logic [DATA_W-1:0] rdata;
    logic rdv;
    logic wreq;
    logic [DATA_W-1:0] status;
    int fail_count = 0;
    int total_checks = 0;
    logic [DATA_W-1:0] q;

    dma_channel_flag_status #(.CHANNELS(NUM_CHAN)) u_dut (.i_clk(i_clk), .i_reset_n(i_reset_n),
        .i_chan_events(ev), .i_bus(bus), .o_readdata(rdata), .o_readdatavalid(rdv),
        .o_waitrequest(wreq), .o_flag_status(status));

    always #20 i_clk = ~i_clk;

    // ----------------------------------------
    // Shared tasks
    // ----------------------------------------
    task automatic chk(input string name, input logic [DATA_W-1:0] seen, input logic [DATA_W-1:0] exp);
        total_checks++;
        if (seen !== exp)
        begin
            fail_count++;
            $display("[FAIL] %s expected %h seen %h", name, exp, seen);
        end
    endtask : chk

    // Holds the request until waitrequest is sampled low
    task automatic acc(input logic wr, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
        bus <= '{read: !wr, write: wr, address: a, writedata: d};
        do
        begin
            @(posedge i_clk);
        end
        while (wreq !== 1'b0);
        q = rdata;
        if (!wr) chk("readdatavalid", {31'h0, rdv}, 32'h1);
        bus <= '0;
        @(posedge i_clk);
    endtask : acc

    task automatic rd(input string name, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] exp);
        acc(1'b0, a, 32'h0);
        chk(name, q, exp);
    endtask : rd

    // Pulse, then wait until the registered copy shows it
    task automatic pulse(input int ch, input chan_events_t e);
        ev[ch] <= e;
        @(posedge i_clk);
        ev <= '0;
        repeat (3) @(posedge i_clk);
    endtask : pulse

    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    task automatic t_reset;
        chk("status reset", status, FLAG_RESET);
        rd("status read reset", OFS_STATUS, FLAG_RESET);
        rd("clear reads zero", OFS_CLEAR, READ_ZERO);
    endtask : t_reset

    // Every event kind on every channel, then group clear
    task automatic t_map;
        logic [DATA_W-1:0] e;
        for (int ch = 0; ch < NUM_CHAN; ch++)
            for (int j = 0; j < 3; j++)
            begin
                e = (32'h1 | (32'h2 << j)) << (GRP_W * ch);
                pulse(ch, chan_events_t'(3'h1 << j));
                chk("flag word", status, e);
                rd("flag read", OFS_STATUS, e);
                acc(1'b1, OFS_CLEAR, 32'h1 << (GRP_W * ch));
                rd("group clear", OFS_STATUS, 32'h0);
            end
    endtask : t_map

    task automatic t_single_clear;
        pulse(5, 3'h5);
        chk("ch5 done and error", status, 32'h00b0_0000);
        acc(1'b1, OFS_CLEAR, 32'h0020_0000);
        rd("done cleared only", OFS_STATUS, 32'h0090_0000);
        acc(1'b1, OFS_CLEAR, 32'h0);
        rd("zero write no effect", OFS_STATUS, 32'h0090_0000);
        acc(1'b1, OFS_CLEAR, 32'h0080_0000);
        rd("error cleared only", OFS_STATUS, 32'h0010_0000);
        acc(1'b1, OFS_CLEAR, 32'h0010_0000);
        rd("any flag cleared", OFS_STATUS, 32'h0);
    endtask : t_single_clear

    task automatic t_refused;
        pulse(7, 3'h2);
        acc(1'b1, OFS_STATUS, 32'hffff_ffff);
        rd("status ignores write", OFS_STATUS, 32'h5000_0000);
        acc(1'b1, 4'h8, 32'hffff_ffff);
        rd("unmapped write ignored", OFS_STATUS, 32'h5000_0000);
        rd("unmapped reads zero", 4'h8, 32'h0);
        acc(1'b1, OFS_CLEAR, 32'hffff_ffff);
        rd("clear all", OFS_STATUS, 32'h0);
    endtask : t_refused

    // Reset in mid-run must wipe flags already set
    task automatic t_mid_reset;
        pulse(4, 3'h7);
        chk("ch4 all flags", status, 32'h000f_0000);
        i_reset_n <= 1'b0;
        repeat (2) @(posedge i_clk);
        i_reset_n <= 1'b1;
        @(posedge i_clk);
        chk("status after reset", status, FLAG_RESET);
        rd("read after reset", OFS_STATUS, FLAG_RESET);
    endtask : t_mid_reset

    // Error pulse lands on the edge where the clear takes effect
    task automatic t_set_wins;
        bus <= '{read: 1'b0, write: 1'b1, address: OFS_CLEAR, writedata: 32'h0f00_0000};
        @(posedge i_clk);
        ev[6] <= 3'h4;
        @(posedge i_clk);
        chk("one wait state", {31'h0, wreq}, 32'h0);
        ev <= '0;
        while (wreq !== 1'b0)
            @(posedge i_clk);
        bus <= '0;
        @(posedge i_clk);
        rd("set beats clear", OFS_STATUS, 32'h0900_0000);
    endtask : t_set_wins

    task automatic results;
        $display("checks %0d mismatches %0d", total_checks, fail_count);
        if (fail_count == 0 && total_checks > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask : results

    initial
    begin
        i_clk = 1'b0;
        i_reset_n = 1'b0;
        bus = '0;
        ev = '0;
        repeat (10) @(posedge i_clk);
        i_reset_n <= 1'b1;
        @(posedge i_clk);
        t_reset;
        t_map;
        t_single_clear;
        t_refused;
        t_mid_reset;
        t_set_wins;
        results;
    end

    // Roughly 400 cycles expected; allow a wide margin
    initial
    begin
        #(4000 * 40);
        fail_count++;
        results;
    end
endmodule : test_dma_channel_flag_status
`default_nettype wire
